// *** vfid_pkg.sv ***
// Constants, carriers and lookup for the video format identification block
package vfid_pkg;
  localparam logic [11:0] ADDR_STD   = 12'h004;
  localparam logic [11:0] ADDR_PID_A = 12'h00C;
  localparam logic [11:0] ADDR_PID_B = 12'h00D;
  localparam logic [11:0] ADDR_AWPL  = 12'h00E;
  localparam logic [11:0] ADDR_TWPL  = 12'h00F;
  localparam logic [11:0] ADDR_TLPF  = 12'h010;
  localparam logic [11:0] ADDR_ALPF  = 12'h011;

  localparam int WPL_W = 12;
  localparam int LPF_W = 11;
  localparam int CNT_W = 13;

  localparam logic [9:0] TRS_ONES = 10'h3FF;
  localparam logic [9:0] TRS_ZERO = 10'h000;
  localparam int XYZ_F = 8;
  localparam int XYZ_V = 7;
  localparam int XYZ_H = 6;
  localparam logic [7:0] PID_DID  = 8'h41;
  localparam logic [7:0] PID_SDID = 8'h01;
  localparam logic [7:0] PID_DC   = 8'h04;
  localparam logic [1:0] PID_LAST = 2'h3;

  localparam logic [WPL_W-1:0] EAV_TAIL   = 12'h003;
  localparam logic [LPF_W-1:0] LINE_FIRST = 11'h001;
  localparam logic [LPF_W-1:0] LINE_UPD   = 11'h00C;
  localparam logic [1:0] FLY_FRAMES         = 2'h2;
  localparam logic [1:0] PID_TIMEOUT_FRAMES = 2'h2;
  localparam logic [1:0] PID_BOUNDS = PID_TIMEOUT_FRAMES + 2'h1;

  localparam logic [3:0] FMT_SDI  = 4'h6;
  localparam logic [3:0] FMT_ASI  = 4'h7;
  localparam logic [3:0] FMT_TDM  = 4'h8;
  localparam logic [3:0] FMT_NONE = 4'hF;
  localparam logic [4:0] STD_NONE = 5'h00;

  typedef struct packed {
    logic sd_mode;
    logic asi_mode;
    logic thru;
    logic smpte;
    logic lock;
  } pin_s;

  typedef struct packed {
    logic [7:0] w4;
    logic [7:0] w3;
    logic [7:0] w2;
    logic [7:0] w1;
  } pid_s;

  typedef struct packed {
    logic       unused;
    logic [4:0] code;
    logic       intl;
    logic       sync;
    logic [3:0] chroma;
    logic [3:0] luma;
  } std_status_s;

  function automatic logic [4:0] std_lookup(
    input logic [CNT_W-1:0] tot,
    input logic [WPL_W-1:0] act,
    input logic             intl,
    input logic             hd
  );
    logic [4:0] c;
    c = hd ? 5'h1D : 5'h1E;
    if (hd) begin
      case (tot)
        13'h0672: c = (act == 12'h5A0) ? 5'h01 : 5'h00;
        13'h0CE4: c = (act == 12'hB40) ? 5'h03 : 5'h02;
        13'h07BC: c = (act == 12'h6C0) ? 5'h05 : 5'h04;
        13'h0F78: c = (act == 12'hD80) ? 5'h07 : 5'h06;
        13'h101D: c = (act == 12'hE10) ? 5'h09 : 5'h08;
        13'h0898: c = intl ? 5'h0A : 5'h0B;
        13'h0A50: c = (act == 12'h900) ? (intl ? 5'h0F : 5'h0E)
                                       : (intl ? 5'h0C : 5'h0D);
        13'h0ABE: c = (act == 12'h960) ? (intl ? 5'h13 : 5'h12)
                                       : (intl ? 5'h11 : 5'h10);
        13'h0948: c = 5'h14;
        default:  c = 5'h1D;
      endcase
    end else begin
      case (tot)
        13'h06B4: c = 5'h16;
        13'h06C0: c = 5'h18;
        default:  c = 5'h1E;
      endcase
    end
    return c;
  endfunction : std_lookup
endpackage : vfid_pkg

// *** payload_id_parser.sv ***
// Payload identifier ancillary packet parser with checksum check
`timescale 1ns/1ps
module payload_id_parser
  import vfid_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       nrst_i,
  input  wire logic [9:0] word_i,
  output logic            pid_valid_o,
  output pid_s            pid_o
);
  typedef enum logic [7:0] {
    P_IDLE = 8'h01, P_ADF1 = 8'h02, P_ADF2 = 8'h04, P_DID  = 8'h08,
    P_SDID = 8'h10, P_DC   = 8'h20, P_UDW  = 8'h40, P_CS   = 8'h80
  } pst_e;

  pst_e             st;
  pst_e             next_st;
  logic [8:0]       sum;
  logic [1:0]       idx;
  logic [3:0][7:0]  udw;

  always_comb begin
    next_st = P_IDLE;
    unique case (st)
      P_IDLE: next_st = (word_i == TRS_ZERO) ? P_ADF1 : P_IDLE;
      P_ADF1: next_st = (word_i == TRS_ONES) ? P_ADF2 :
                        (word_i == TRS_ZERO) ? P_ADF1 : P_IDLE;
      P_ADF2: next_st = (word_i == TRS_ONES) ? P_DID : P_IDLE;
      P_DID:  next_st = (word_i[7:0] == PID_DID) ? P_SDID : P_IDLE;
      P_SDID: next_st = (word_i[7:0] == PID_SDID) ? P_DC : P_IDLE;
      P_DC:   next_st = (word_i[7:0] == PID_DC) ? P_UDW : P_IDLE;
      P_UDW:  next_st = (idx == PID_LAST) ? P_CS : P_UDW;
      P_CS:   next_st = P_IDLE;
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      st <= P_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // Checksum covers the 9 low bits of DID through the last user word
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      sum <= '0;
      idx <= '0;
      udw <= '0;
    end else begin
      if (st == P_DID) begin
        sum <= word_i[8:0];
        idx <= '0;
      end else if (st == P_SDID || st == P_DC || st == P_UDW) begin
        sum <= sum + word_i[8:0];
      end
      if (st == P_UDW) begin
        udw[idx] <= word_i[7:0];
        idx      <= idx + 2'h1;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pid_valid_o <= 1'b0;
      pid_o       <= '0;
    end else begin
      pid_valid_o <= (st == P_CS) && (word_i[8:0] == sum);
      if (st == P_CS && word_i[8:0] == sum) begin
        pid_o <= pid_s'(udw);
      end
    end
  end
endmodule : payload_id_parser

// *** vid_format_ident.sv ***
// Video format identification status logic behind the host port
`timescale 1ns/1ps
module vid_format_ident
  import vfid_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic [9:0]  word_i,
  input  wire pin_s        pins_i,
  input  wire logic [3:0]  luma_fmt_i,
  input  wire logic [3:0]  chroma_fmt_i,
  input  wire logic [11:0] hif_addr_i,
  input  wire logic        hif_rd_i,
  input  wire logic        hif_wr_i,
  output logic [15:0]      hif_rdata_o,
  output logic             hif_ack_o
);
  pin_s             pin_meta;
  pin_s             pin_sync;
  logic             lost_id;
  logic             fmt_dflt;
  logic             hd;
  logic [9:0]       w1;
  logic [9:0]       w2;
  logic [9:0]       w3;
  logic             trs_xyz;
  logic             eav;
  logic             sav;
  logic             fbit;
  logic             vbit;
  logic [CNT_W-1:0] wcnt;
  logic [CNT_W-1:0] line_total;
  logic [WPL_W-1:0] acnt;
  logic [WPL_W-1:0] line_active;
  logic             last_v;
  logic             last_f;
  logic             frame_start;
  logic             saw_f;
  logic             interlaced;
  logic [LPF_W-1:0] lcnt;
  logic [LPF_W-1:0] frame_lines;
  logic [LPF_W-1:0] alcnt;
  logic [LPF_W-1:0] field_active;
  logic             upd;
  logic [CNT_W-1:0] prev_total;
  logic [LPF_W-1:0] prev_lines;
  logic [1:0]       fly_cnt;
  logic [4:0]       std_code;
  logic             intl_flag;
  logic             sync_flag;
  logic [3:0]       luma_fmt;
  logic [3:0]       chroma_fmt;
  logic [WPL_W-1:0] awpl;
  logic [WPL_W-1:0] twpl;
  logic [LPF_W-1:0] tlpf;
  logic [LPF_W-1:0] alpf;
  logic             pid_valid;
  pid_s             pid_new;
  logic [15:0]      pid_a;
  logic [15:0]      pid_b;
  logic [1:0]       pid_age;
  logic             pid_expire;
  std_status_s      status;
  logic [15:0]      next_rdata;

  // Pins are asynchronous to the pixel clock
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pin_meta <= '0;
      pin_sync <= '0;
    end else begin
      pin_meta <= pins_i;
      pin_sync <= pin_meta;
    end
  end

  assign lost_id  = !pin_sync.lock || !pin_sync.smpte;
  assign fmt_dflt = !pin_sync.lock || pin_sync.thru;
  assign hd       = !pin_sync.sd_mode;

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      w1 <= '0;
      w2 <= '0;
      w3 <= '0;
    end else begin
      w1 <= word_i;
      w2 <= w1;
      w3 <= w2;
    end
  end

  assign trs_xyz = (w3 == TRS_ONES) && (w2 == TRS_ZERO) &&
                   (w1 == TRS_ZERO);
  assign eav  = trs_xyz && word_i[XYZ_H];
  assign sav  = trs_xyz && !word_i[XYZ_H];
  assign fbit = word_i[XYZ_F];
  assign vbit = word_i[XYZ_V];

  // Word counts: XYZ to XYZ is a total line; SAV to EAV less the
  // three leading EAV words is the active part
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      wcnt        <= '0;
      acnt        <= '0;
      line_total  <= '0;
      line_active <= '0;
    end else begin
      wcnt <= eav ? '0 : wcnt + 1'b1;
      acnt <= sav ? '0 : acnt + 1'b1;
      if (eav) begin
        line_total  <= wcnt + 1'b1;
        line_active <= acnt - EAV_TAIL;
      end
    end
  end

  // Frame begins on the first blanking line of field one
  assign frame_start = eav && vbit && !fbit && (!last_v || last_f);
  assign upd         = eav && (lcnt == LINE_UPD);

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      last_v       <= 1'b0;
      last_f       <= 1'b0;
      lcnt         <= '0;
      frame_lines  <= '0;
      alcnt        <= '0;
      field_active <= '0;
      saw_f        <= 1'b0;
      interlaced   <= 1'b0;
    end else if (eav) begin
      last_v <= vbit;
      last_f <= fbit;
      if (frame_start) begin
        lcnt         <= LINE_FIRST;
        frame_lines  <= lcnt;
        field_active <= alcnt;
        alcnt        <= '0;
        interlaced   <= saw_f;
        saw_f        <= 1'b0;
      end else begin
        lcnt <= lcnt + 1'b1;
        if (!vbit && !fbit) begin
          alcnt <= alcnt + 1'b1;
        end
        if (fbit) begin
          saw_f <= 1'b1;
        end
      end
    end
  end

  // Flywheel counts frames whose raster repeats exactly
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      prev_total <= '0;
      prev_lines <= '0;
      fly_cnt    <= '0;
    end else if (lost_id) begin
      fly_cnt <= '0;
    end else if (frame_start) begin
      prev_total <= line_total;
      prev_lines <= lcnt;
      if (line_total == prev_total && lcnt == prev_lines) begin
        if (fly_cnt != FLY_FRAMES) begin
          fly_cnt <= fly_cnt + 2'h1;
        end
      end else begin
        fly_cnt <= '0;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      std_code  <= STD_NONE;
      intl_flag <= 1'b0;
      sync_flag <= 1'b0;
    end else if (lost_id) begin
      std_code  <= STD_NONE;
      intl_flag <= 1'b0;
      sync_flag <= 1'b0;
    end else begin
      if (upd) begin
        std_code <= std_lookup(line_total, line_active,
                               interlaced, hd);
      end
      intl_flag <= interlaced;
      sync_flag <= (fly_cnt == FLY_FRAMES);
    end
  end

  // Unknown upstream codes fall back to plain serial video
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      luma_fmt   <= FMT_NONE;
      chroma_fmt <= FMT_NONE;
    end else if (fmt_dflt) begin
      luma_fmt   <= FMT_NONE;
      chroma_fmt <= FMT_NONE;
    end else begin
      if (pin_sync.asi_mode) begin
        luma_fmt <= FMT_ASI;
      end else if (luma_fmt_i > FMT_TDM) begin
        luma_fmt <= FMT_SDI;
      end else begin
        luma_fmt <= luma_fmt_i;
      end
      if (!hd || pin_sync.asi_mode) begin
        chroma_fmt <= FMT_NONE;
      end else if (chroma_fmt_i > FMT_TDM) begin
        chroma_fmt <= FMT_SDI;
      end else begin
        chroma_fmt <= chroma_fmt_i;
      end
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      awpl <= '0;
      twpl <= '0;
      tlpf <= '0;
      alpf <= '0;
    end else if (upd) begin
      awpl <= line_active;
      twpl <= line_total[WPL_W-1:0];
      tlpf <= frame_lines;
      alpf <= field_active;
    end
  end

  payload_id_parser u_parser (
    .mclk_i      (mclk_i),
    .nrst_i      (nrst_i),
    .word_i      (word_i),
    .pid_valid_o (pid_valid),
    .pid_o       (pid_new)
  );

  // Age counts frame boundaries since the last good packet; the third
  // boundary closes the second complete frame
  assign pid_expire = frame_start && (pid_age == PID_TIMEOUT_FRAMES);

  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pid_age <= '0;
    end else if (pid_valid) begin
      pid_age <= '0;
    end else if (frame_start && pid_age != PID_BOUNDS) begin
      pid_age <= pid_age + 2'h1;
    end
  end

  // A packet landing with the timeout wins over the clear
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      pid_a <= '0;
      pid_b <= '0;
    end else if (lost_id) begin
      pid_a <= '0;
      pid_b <= '0;
    end else if (pid_valid) begin
      pid_a <= {pid_new.w2, pid_new.w1};
      pid_b <= {pid_new.w4, pid_new.w3};
    end else if (pid_expire) begin
      pid_a <= '0;
      pid_b <= '0;
    end
  end

  always_comb begin
    status        = '0;
    status.code   = std_code;
    status.intl   = intl_flag;
    status.sync   = sync_flag;
    status.chroma = chroma_fmt;
    status.luma   = luma_fmt;
  end

  always_comb begin
    next_rdata = '0;
    case (hif_addr_i)
      ADDR_STD:   next_rdata = status;
      ADDR_PID_A: next_rdata = pid_a;
      ADDR_PID_B: next_rdata = pid_b;
      ADDR_AWPL:  next_rdata = {4'h0, awpl};
      ADDR_TWPL:  next_rdata = {4'h0, twpl};
      ADDR_TLPF:  next_rdata = {5'h00, tlpf};
      ADDR_ALPF:  next_rdata = {5'h00, alpf};
      default:    next_rdata = '0;
    endcase
  end

  // Writes are acknowledged but store nothing
  always_ff @(posedge mclk_i) begin
    if (!nrst_i) begin
      hif_rdata_o <= '0;
      hif_ack_o   <= 1'b0;
    end else begin
      hif_ack_o <= hif_rd_i || hif_wr_i;
      if (hif_rd_i) begin
        hif_rdata_o <= next_rdata;
      end
    end
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!nrst_i);

  sequence seq_line12_end;
    eav && (lcnt == LINE_UPD);
  endsequence

  sequence seq_good_pkt;
    pid_valid && !lost_id;
  endsequence

  chk_pid_store: assert property (
    seq_good_pkt |=> pid_b == {$past(pid_new.w4), $past(pid_new.w3)}
                  && pid_a == {$past(pid_new.w2), $past(pid_new.w1)})
    else $error("payload words not stored");

  chk_pid_hold: assert property (
    !pid_valid && !lost_id && !pid_expire |=> $stable(pid_a)
                                           && $stable(pid_b))
    else $error("payload changed without good packet");

  chk_pid_clear: assert property (
    lost_id |=> pid_a == '0 && pid_b == '0)
    else $error("payload not cleared on unlock or bypass");

  chk_pid_timeout: assert property (
    pid_expire && !pid_valid && !lost_id |=> pid_a == '0 && pid_b == '0)
    else $error("payload not cleared after timeout");

  chk_std_clear: assert property (
    lost_id |=> std_code == STD_NONE && !intl_flag && !sync_flag)
    else $error("standard bits not cleared");

  chk_fmt_default: assert property (
    fmt_dflt |=> luma_fmt == FMT_NONE && chroma_fmt == FMT_NONE)
    else $error("formats not all ones");

  chk_sd_chroma: assert property (
    (!hd || pin_sync.asi_mode) |=> chroma_fmt == FMT_NONE)
    else $error("chroma format not ones in SD or ASI");

  chk_raster_update: assert property (
    seq_line12_end |=> awpl == $past(line_active)
                    && tlpf == $past(frame_lines))
    else $error("raster not refreshed at line 12 end");

  chk_raster_hold: assert property (
    !upd |=> $stable(awpl) && $stable(twpl) && $stable(alpf))
    else $error("raster changed between updates");

  chk_reset_vals: assert property (
    $rose(nrst_i) |-> awpl == '0 && tlpf == '0 && luma_fmt == FMT_NONE)
    else $error("wrong values after reset");

  chk_read_zero: assert property (
    hif_rd_i && hif_addr_i > ADDR_ALPF |=> hif_ack_o
                                        && hif_rdata_o == '0)
    else $error("unmapped read not zero");

  chk_sync_flag: assert property (
    !lost_id && fly_cnt == FLY_FRAMES && !frame_start
      ##1 !lost_id |-> sync_flag)
    else $error("sync flag low while flywheel stream_lock");
endmodule : vid_format_ident

// *** host_model.sv ***
// Host controller model that issues reads and writes on the register port
`timescale 1ns/1ps
module host_model (
  input  wire logic        mclk_i,
  input  wire logic [15:0] rdata_i,
  input  wire logic        ack_i,
  output logic [11:0]      addr_o,
  output logic             rd_o,
  output logic             wr_o
);
  initial begin
    addr_o = 12'h000;
    rd_o   = 1'b0;
    wr_o   = 1'b0;
  end

  // One-cycle strobe; address held until the acknowledge has been sampled
  task automatic access(input logic [11:0] a, input logic w,
                        output logic [15:0] d, output logic ok);
    int n;
    @(posedge mclk_i);
    #1;
    addr_o = a;
    rd_o   = ~w;
    wr_o   = w;
    @(posedge mclk_i);
    #1;
    rd_o = 1'b0;
    wr_o = 1'b0;
    n    = 0;
    while (ack_i !== 1'b1 && n < 4) begin
      @(posedge mclk_i);
      #1;
      n++;
    end
    ok = (ack_i === 1'b1);
    d  = rdata_i;
  endtask : access
endmodule : host_model

// *** tb_video_format_identification.sv ***
// Self-checking bench for the video format identification status logic
`timescale 1ns/1ps
module tb_video_format_identification;
  import vfid_pkg::*;
  logic        mclk;
  logic        nrst;
  logic [9:0]  word;
  pin_s        pins;
  logic [3:0]  luma_fmt;
  logic [3:0]  chroma_fmt;
  logic [11:0] hif_addr;
  logic        hif_rd;
  logic        hif_wr;
  logic [15:0] hif_rdata;
  logic        hif_ack;
  pid_s        pid_tx;
  int          n_errors;
  int          n_tests;
  logic [11:0] regs [0:7] = '{ADDR_STD, ADDR_PID_A, ADDR_PID_B, ADDR_AWPL,
                              ADDR_TWPL, ADDR_TLPF, ADDR_ALPF, 12'h012};

  vid_format_ident uut (
    .mclk_i       (mclk),
    .nrst_i       (nrst),
    .word_i       (word),
    .pins_i       (pins),
    .luma_fmt_i   (luma_fmt),
    .chroma_fmt_i (chroma_fmt),
    .hif_addr_i   (hif_addr),
    .hif_rd_i     (hif_rd),
    .hif_wr_i     (hif_wr),
    .hif_rdata_o  (hif_rdata),
    .hif_ack_o    (hif_ack)
  );

  host_model host (
    .mclk_i  (mclk),
    .rdata_i (hif_rdata),
    .ack_i   (hif_ack),
    .addr_o  (hif_addr),
    .rd_o    (hif_rd),
    .wr_o    (hif_wr)
  );

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp,
                       input string what);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: %s got %h want %h", $time, what, seen,
               exp);
    end
  endtask : check

  task automatic rd_chk(input logic [11:0] a, input logic [15:0] exp);
    logic [15:0] d;
    logic        ok;
    host.access(a, 1'b0, d, ok);
    check({15'h0000, ok}, 16'h0001, "read ack");
    check(d, exp, "read data");
  endtask : rd_chk

  function automatic logic [9:0] anc(input logic [7:0] b);
    return {~^b, ^b, b};
  endfunction : anc

  // Field bit is always 0: the test raster is progressive
  function automatic logic [9:0] xyz(input logic v, input logic h);
    return {2'b10, v, h, v ^ h, h, v, v ^ h, 2'b00};
  endfunction : xyz

  task automatic put(input logic [9:0] w);
    @(posedge mclk);
    #1;
    word = w;
  endtask : put

  // 48 words a line, 24 active; packet sits in horizontal blanking
  task automatic send_line(input logic v, input logic pid, input logic bad);
    logic [9:0] pkt [0:10];
    logic [9:0] ln [0:47];
    logic [8:0] sum;
    pkt = '{10'h000, 10'h3FF, 10'h3FF, anc(8'h41), anc(8'h01), anc(8'h04),
            anc(pid_tx.w1), anc(pid_tx.w2), anc(pid_tx.w3), anc(pid_tx.w4),
            10'h000};
    sum = 9'h000;
    for (int i = 3; i < 10; i++) sum += pkt[i][8:0];
    pkt[10] = {~sum[8], sum ^ {8'h00, bad}};
    for (int i = 0; i < 48; i++) ln[i] = (i < 24) ? 10'h040 : 10'h200;
    ln[0]  = 10'h3FF;
    ln[1]  = 10'h000;
    ln[2]  = 10'h000;
    ln[3]  = xyz(v, 1'b1);
    ln[20] = 10'h3FF;
    ln[21] = 10'h000;
    ln[22] = 10'h000;
    ln[23] = xyz(v, 1'b0);
    if (pid) for (int i = 0; i < 11; i++) ln[5 + i] = pkt[i];
    for (int i = 0; i < 48; i++) put(ln[i]);
  endtask : send_line

  // 16 lines: 6 blanking then 10 active, one packet a frame
  task automatic send_frame(input logic pid, input logic bad);
    for (int n = 1; n <= 16; n++) send_line(n <= 6, pid && n == 2, bad);
  endtask : send_frame

  task automatic t_reset;
    for (int i = 0; i < 8; i++) begin
      rd_chk(regs[i], (i == 0) ? 16'h00FF : 16'h0000);
    end
    $display("test reset values done");
  endtask : t_reset

  task automatic t_measure;
    pins.lock = 1'b1;
    pid_tx    = 32'h1E2D3C4B;
    // First frame start compares against reset zeros; two real matches
    // are needed before the flywheel reports sync
    repeat (4) send_frame(1'b1, 1'b0);
    rd_chk(ADDR_STD, {1'b0, 5'h1D, 1'b0, 1'b1, 4'h5, 4'h3});
    rd_chk(ADDR_PID_A, 16'h3C4B);
    rd_chk(ADDR_PID_B, 16'h1E2D);
    rd_chk(ADDR_AWPL, 16'h0018);
    rd_chk(ADDR_TWPL, 16'h0030);
    rd_chk(ADDR_TLPF, 16'h0010);
    rd_chk(ADDR_ALPF, 16'h000A);
    $display("test measurement done");
  endtask : t_measure

  task automatic t_timeout;
    pid_tx = 32'h55667788;
    send_frame(1'b1, 1'b1);
    rd_chk(ADDR_PID_A, 16'h3C4B);
    send_frame(1'b0, 1'b0);
    rd_chk(ADDR_PID_B, 16'h1E2D);
    send_frame(1'b0, 1'b0);
    rd_chk(ADDR_PID_A, 16'h0000);
    rd_chk(ADDR_PID_B, 16'h0000);
    $display("test checksum and timeout done");
  endtask : t_timeout

  task automatic t_write;
    logic [15:0] ex [0:7] = '{16'h7553, 16'h0000, 16'h0000, 16'h0018,
                              16'h0030, 16'h0010, 16'h000A, 16'h0000};
    logic [15:0] d;
    logic        ok;
    for (int i = 0; i < 8; i++) begin
      host.access(regs[i], 1'b1, d, ok);
      check({15'h0000, ok}, 16'h0001, "write ack");
    end
    for (int i = 0; i < 8; i++) rd_chk(regs[i], ex[i]);
    $display("test read-only done");
  endtask : t_write

  task automatic t_modes;
    logic [2:0]  md [0:5] = '{3'h0, 3'h4, 3'h2, 3'h1, 3'h0, 3'h0};
    logic [3:0]  lf [0:5] = '{4'h3, 4'h0, 4'h2, 4'h3, 4'h8, 4'hC};
    logic [7:0]  ex [0:5] = '{8'h53, 8'hF0, 8'hF7, 8'hFF, 8'h58, 8'h56};
    logic [15:0] d;
    logic        ok;
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      #1;
      {pins.sd_mode, pins.asi_mode, pins.thru} = md[i];
      luma_fmt = lf[i];
      repeat (4) @(posedge mclk);
      host.access(ADDR_STD, 1'b0, d, ok);
      check({8'h00, d[7:0]}, {8'h00, ex[i]}, "format bits");
    end
    luma_fmt = 4'h3;
    $display("test format modes done");
  endtask : t_modes

  task automatic t_clear;
    pid_tx = 32'hA1B2C3D4;
    send_frame(1'b1, 1'b0);
    rd_chk(ADDR_PID_A, 16'hC3D4);
    pins.smpte = 1'b0;
    repeat (4) @(posedge mclk);
    rd_chk(ADDR_STD, 16'h0053);
    rd_chk(ADDR_PID_B, 16'h0000);
    pins.smpte = 1'b1;
    pins.lock  = 1'b0;
    repeat (4) @(posedge mclk);
    rd_chk(ADDR_STD, 16'h00FF);
    rd_chk(ADDR_PID_A, 16'h0000);
    rd_chk(ADDR_TLPF, 16'h0010);
    $display("test clear conditions done");
  endtask : t_clear

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run

  // Lock starts low so the format fields show their reset value
  initial begin
    nrst       = 1'b0;
    word       = 10'h040;
    pins       = 5'h02;
    luma_fmt   = 4'h3;
    chroma_fmt = 4'h5;
    pid_tx     = 32'h00000000;
    n_errors   = 0;
    n_tests    = 0;
    repeat (5) @(posedge mclk);
    #1;
    nrst = 1'b1;
    t_reset();
    t_measure();
    t_timeout();
    t_write();
    t_modes();
    t_clear();
    complete_run();
  end

  // About 6300 cycles of traffic are expected; allow well over that
  initial begin
    #1000000;
    n_errors++;
    complete_run();
  end
endmodule : tb_video_format_identification
